// ---- inc/flash_host_pkg.sv ----
// Shared constants for the flash write-status host controller.
// Assumes a 100 MHz mclk and a 16-bit parallel NOR flash in word mode.
package flash_host_pkg;
    // Clock and pin timing, in ns, then in whole mclk cycles
    localparam int CLK_NS = 10;
    localparam int T_WE_LOW_NS = 50;
    localparam int T_WE_HIGH_NS = 30;
    localparam int T_RD_LOW_NS = 100;
    localparam int T_RD_HIGH_NS = 30;
    localparam int SYNC_LAT = 3; // Extra read cycles covering the input synchroniser
    localparam int N_WE_LOW = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int N_WE_HIGH = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int N_RD_LOW = (T_RD_LOW_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
    localparam int N_RD_HIGH = (T_RD_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 5;

    // Bus widths
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    // Status bit positions on the data bus
    localparam int COMPLEMENT_POLL_BIT = 7;
    localparam int TOGGLE_ONE_BIT = 6;
    localparam int TIMING_LIMIT_FAIL_BIT = 5;
    localparam int ERASE_WINDOW_BIT = 3;
    localparam int SECTOR_TOGGLE_BIT = 2;

    // Command cycle addresses and codes (plain defaults, adjustable)
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 20'h0_0555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 20'h0_02aa;
    localparam logic [DATA_W-1:0] UNLOCK_CODE_A = 16'h00aa;
    localparam logic [DATA_W-1:0] UNLOCK_CODE_B = 16'h0055;
    localparam logic [DATA_W-1:0] CODE_PROGRAM = 16'h00a0;
    localparam logic [DATA_W-1:0] CODE_ERASE_SETUP = 16'h0080;
    localparam logic [DATA_W-1:0] CODE_SECTOR_ERASE = 16'h0030;
    localparam logic [DATA_W-1:0] CODE_CHIP_ERASE = 16'h0010;
    localparam logic [DATA_W-1:0] CODE_SUSPEND = 16'h00b0;
    localparam logic [DATA_W-1:0] CODE_RESUME = 16'h0030;
    localparam logic [DATA_W-1:0] CODE_RESET = 16'h00f0;

    // Operations offered on the user command port
    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_PROGRAM = 4'h1,
        OP_SECTOR_ERASE = 4'h2,
        OP_ADD_SECTOR = 4'h3,
        OP_CHIP_ERASE = 4'h4,
        OP_SUSPEND = 4'h5,
        OP_RESUME = 4'h6,
        OP_RESET = 4'h7,
        OP_WAIT = 4'h8
    } op_e;
endpackage

// ---- src/pin_sync.sv ----
// Three-stage synchroniser for asynchronous flash pins.
// Assumes inputs arrive from outside the mclk domain.
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Chain; first stage feeds only the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Per bit, accept a change only once stages two and three agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= (s2 & s3) | (q & (s2 ^ s3));
        end
    end
endmodule

// ---- src/flash_status_host.sv ----
// Host controller that issues program/erase commands to a parallel NOR
// flash and tracks write-operation status through read polling.
// Assumes the flash pins are wired directly; dq is tri-stated outside.
// Functional notes
// - After seeing the fail bit, host rereads and writes the reset command only if the toggle bit still toggles.
// - Host may skip window checks only with sub-50 us command spacing.
// - Host confirms acceptance, checks window bit before and after each add.
// - Status reads must use a valid address within the relevant sector.
`timescale 1ns/100ps
module flash_status_host (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire flash_host_pkg::op_e cmd_op,
    input wire logic [flash_host_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] cmd_data,
    output logic done,
    output logic [flash_host_pkg::DATA_W-1:0] result_data,
    output logic result_fail,
    output logic result_window,
    output logic result_rejected,
    output logic flash_ready,
    output logic [flash_host_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output logic [flash_host_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    input wire logic ready_busy_out
);
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_PRECHK = 4'h1,
        S_WRITE = 4'h2,
        S_POLL_A = 4'h3,
        S_POLL_B = 4'h4,
        S_RECHK_A = 4'h5,
        S_RECHK_B = 4'h6,
        S_CONFIRM_A = 4'h7,
        S_CONFIRM_B = 4'h8,
        S_RESET_WR = 4'h9,
        S_READ = 4'ha,
        S_DONE = 4'hb
    } state_e;

    localparam logic [flash_host_pkg::CNT_W-1:0] WE_LOW_LAST =
        flash_host_pkg::CNT_W'(flash_host_pkg::N_WE_LOW - 1);
    localparam logic [flash_host_pkg::CNT_W-1:0] WE_HIGH_LAST =
        flash_host_pkg::CNT_W'(flash_host_pkg::N_WE_HIGH - 1);
    localparam logic [flash_host_pkg::CNT_W-1:0] RD_LOW_LAST =
        flash_host_pkg::CNT_W'(flash_host_pkg::N_RD_LOW - 1);
    localparam logic [flash_host_pkg::CNT_W-1:0] RD_HIGH_LAST =
        flash_host_pkg::CNT_W'(flash_host_pkg::N_RD_HIGH - 1);

    state_e state;
    flash_host_pkg::op_e op;
    logic [flash_host_pkg::ADDR_W-1:0] op_addr;
    logic [flash_host_pkg::DATA_W-1:0] op_data;
    logic [2:0] step;
    logic [2:0] last_step;
    logic prev_toggle;
    logic bus_act;
    logic bus_wr;
    logic bus_high;
    logic [flash_host_pkg::CNT_W-1:0] bus_cnt;
    logic [flash_host_pkg::DATA_W-1:0] bus_rdata;
    logic bus_done;
    logic bus_need;
    logic bus_req;
    logic need_wr;
    logic [flash_host_pkg::ADDR_W-1:0] req_addr;
    logic [flash_host_pkg::DATA_W-1:0] req_data;
    logic [flash_host_pkg::DATA_W-1:0] dq_sync;
    logic toggled;
    logic reset_sent;
    logic win_low_seen;

    // Pins from the flash are asynchronous to mclk
    pin_sync #(.W(flash_host_pkg::DATA_W)) dq_sync_i (
        .mclk(mclk),
        .resetn(resetn),
        .d(dq_in),
        .q(dq_sync)
    );
    pin_sync #(.W(1)) rb_sync_i (
        .mclk(mclk),
        .resetn(resetn),
        .d(ready_busy_out),
        .q(flash_ready)
    );

    assign cmd_ready = (state == S_IDLE);
    assign done = (state == S_DONE);
    assign toggled = bus_rdata[flash_host_pkg::TOGGLE_ONE_BIT] ^ prev_toggle;

    // Number of write cycles for each command sequence, less one
    always_comb begin
        unique case (op)
            flash_host_pkg::OP_PROGRAM: last_step = 3'h3;
            flash_host_pkg::OP_SECTOR_ERASE: last_step = 3'h5;
            flash_host_pkg::OP_CHIP_ERASE: last_step = 3'h5;
            default: last_step = 3'h0;
        endcase
    end

    // Address and data of the current bus cycle
    always_comb begin
        need_wr = (state == S_WRITE) || (state == S_RESET_WR);
        bus_need = (state != S_IDLE) && (state != S_DONE);
        req_addr = op_addr; // Status reads use the target sector address
        req_data = flash_host_pkg::CODE_RESET;
        if (state == S_WRITE) begin
            unique case (step)
                3'h0, 3'h3: begin
                    req_addr = flash_host_pkg::UNLOCK_ADDR_A;
                    req_data = flash_host_pkg::UNLOCK_CODE_A;
                end
                3'h1, 3'h4: begin
                    req_addr = flash_host_pkg::UNLOCK_ADDR_B;
                    req_data = flash_host_pkg::UNLOCK_CODE_B;
                end
                3'h2: begin
                    req_addr = flash_host_pkg::UNLOCK_ADDR_A;
                    req_data = (op == flash_host_pkg::OP_PROGRAM) ?
                        flash_host_pkg::CODE_PROGRAM : flash_host_pkg::CODE_ERASE_SETUP;
                end
                default: begin
                    req_addr = op_addr;
                    req_data = flash_host_pkg::CODE_SECTOR_ERASE;
                end
            endcase
            // Chip erase ends on the unlock address; no window follows
            if (step == last_step) begin
                req_addr = op_addr; // Last cycle goes to the target word or sector
                unique case (op)
                    flash_host_pkg::OP_PROGRAM: req_data = op_data;
                    flash_host_pkg::OP_CHIP_ERASE: begin
                        req_addr = flash_host_pkg::UNLOCK_ADDR_A;
                        req_data = flash_host_pkg::CODE_CHIP_ERASE;
                    end
                    flash_host_pkg::OP_SUSPEND: req_data = flash_host_pkg::CODE_SUSPEND;
                    flash_host_pkg::OP_RESUME: req_data = flash_host_pkg::CODE_RESUME;
                    flash_host_pkg::OP_RESET: req_data = flash_host_pkg::CODE_RESET;
                    default: req_data = flash_host_pkg::CODE_SECTOR_ERASE;
                endcase
            end
        end
    end

    assign bus_req = bus_need && !bus_act;
    assign bus_done = bus_act && bus_high &&
        (bus_cnt == (bus_wr ? WE_HIGH_LAST : RD_HIGH_LAST));

    // Pin cycle engine; strobes come straight from flops to avoid glitches
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_act <= 1'b0;
            bus_wr <= 1'b0;
            bus_high <= 1'b0;
            bus_cnt <= '0;
            bus_rdata <= '0;
            flash_addr <= '0;
            dq_out <= '0;
            dq_oe <= 1'b0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
        end else if (bus_req) begin
            bus_act <= 1'b1;
            bus_wr <= need_wr;
            bus_high <= 1'b0;
            bus_cnt <= '0;
            flash_addr <= req_addr;
            dq_out <= req_data;
            dq_oe <= need_wr;
            ce_n <= 1'b0;
            oe_n <= need_wr;
            we_n <= !need_wr;
        end else if (bus_act && !bus_high) begin
            if (bus_cnt == (bus_wr ? WE_LOW_LAST : RD_LOW_LAST)) begin
                bus_high <= 1'b1;
                bus_cnt <= '0;
                oe_n <= 1'b1;
                we_n <= 1'b1;
                if (!bus_wr) begin
                    bus_rdata <= dq_sync; // Sampled after the sync latency has passed
                end
            end else begin
                bus_cnt <= bus_cnt + 1'b1;
            end
        end else if (bus_done) begin
            bus_act <= 1'b0;
            ce_n <= 1'b1;
            dq_oe <= 1'b0;
        end else if (bus_act) begin
            bus_cnt <= bus_cnt + 1'b1;
        end
    end

    // Operation sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            op <= flash_host_pkg::OP_READ;
            op_addr <= '0;
            op_data <= '0;
            step <= '0;
            prev_toggle <= 1'b0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    step <= '0;
                    if (cmd_valid) begin
                        op <= cmd_op;
                        op_addr <= cmd_addr;
                        op_data <= cmd_data;
                        unique case (cmd_op)
                            flash_host_pkg::OP_ADD_SECTOR: state <= S_PRECHK;
                            flash_host_pkg::OP_READ: state <= S_READ;
                            flash_host_pkg::OP_WAIT: state <= S_POLL_A;
                            default: state <= S_WRITE;
                        endcase
                    end
                end
                S_PRECHK: begin
                    // Window already closed: erase runs, the add would be ignored
                    if (bus_done) begin
                        state <= bus_rdata[flash_host_pkg::ERASE_WINDOW_BIT] ? S_DONE : S_WRITE;
                    end
                end
                S_WRITE: begin
                    if (bus_done) begin
                        step <= step + 1'b1;
                        if (step == last_step) begin
                            unique case (op)
                                flash_host_pkg::OP_PROGRAM,
                                flash_host_pkg::OP_CHIP_ERASE,
                                flash_host_pkg::OP_SUSPEND: state <= S_POLL_A;
                                flash_host_pkg::OP_SECTOR_ERASE,
                                flash_host_pkg::OP_ADD_SECTOR: state <= S_CONFIRM_A;
                                default: state <= S_DONE;
                            endcase
                        end
                    end
                end
                S_POLL_A, S_RECHK_A, S_CONFIRM_A: begin
                    if (bus_done) begin
                        prev_toggle <= bus_rdata[flash_host_pkg::TOGGLE_ONE_BIT];
                        state <= state_e'(state + 4'h1);
                    end
                end
                S_POLL_B: begin
                    // Toggle stopped means done; fail bit forces one recheck
                    if (bus_done) begin
                        if (!toggled) begin
                            state <= S_DONE;
                        end else if (bus_rdata[flash_host_pkg::TIMING_LIMIT_FAIL_BIT]) begin
                            state <= S_RECHK_A;
                        end else begin
                            state <= S_POLL_A;
                        end
                    end
                end
                S_RECHK_B: begin
                    if (bus_done) begin
                        state <= toggled ? S_RESET_WR : S_DONE;
                    end
                end
                S_CONFIRM_B, S_READ: begin
                    if (bus_done) begin
                        state <= S_DONE;
                    end
                end
                S_RESET_WR: begin
                    if (bus_done) begin
                        state <= S_DONE; // Reset command returns the flash to array reads
                    end
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Results; flags cleared at the start of each operation, result_data kept until the next read
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            result_data <= '0;
            result_fail <= 1'b0;
            result_window <= 1'b0;
            result_rejected <= 1'b0;
        end else if (state == S_IDLE && cmd_valid) begin
            result_fail <= 1'b0;
            result_window <= 1'b0;
            result_rejected <= 1'b0;
        end else if (bus_done && !bus_wr) begin
            result_data <= bus_rdata;
            if (state == S_RECHK_B && toggled) begin
                result_fail <= 1'b1;
            end
            if (state == S_PRECHK || state == S_CONFIRM_B) begin
                // High after the add means it may have been refused
                result_window <= bus_rdata[flash_host_pkg::ERASE_WINDOW_BIT];
                result_rejected <= (op == flash_host_pkg::OP_ADD_SECTOR) &&
                    bus_rdata[flash_host_pkg::ERASE_WINDOW_BIT];
            end
        end
    end

    // Helper state for the checks below
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reset_sent <= 1'b0;
            win_low_seen <= 1'b0;
        end else if (state == S_IDLE) begin
            reset_sent <= 1'b0;
            win_low_seen <= 1'b0;
        end else begin
            if (state == S_RESET_WR && bus_done) begin
                reset_sent <= 1'b1;
            end
            if (state == S_PRECHK && bus_done && !bus_rdata[flash_host_pkg::ERASE_WINDOW_BIT]) begin
                win_low_seen <= 1'b1;
            end
        end
    end

    sequence write_low_s;
        !we_n [*5];
    endsequence

    sequence write_end_s;
        we_n && !ce_n;
    endsequence

    a_we_pulse_width: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(we_n) |-> write_low_s ##1 write_end_s)
        else $error("write strobe width wrong");

    a_fail_sends_reset: assert property (@(posedge mclk) disable iff (!resetn)
        (done && result_fail) |-> reset_sent)
        else $error("failure reported without reset command");

    a_add_prechecked: assert property (@(posedge mclk) disable iff (!resetn)
        (op == flash_host_pkg::OP_ADD_SECTOR && state == S_WRITE && bus_req) |-> win_low_seen)
        else $error("sector added without window check");

    a_status_address: assert property (@(posedge mclk) disable iff (!resetn)
        (bus_req && !need_wr) |=> (flash_addr == op_addr && !oe_n))
        else $error("status read at wrong address");

    a_reject_flag: assert property (@(posedge mclk) disable iff (!resetn)
        (state == S_PRECHK && bus_done && bus_rdata[flash_host_pkg::ERASE_WINDOW_BIT])
        |=> done && result_rejected)
        else $error("closed window not reported");

    a_fail_reset_within: assert property (@(posedge mclk) disable iff (!resetn)
        (state == S_RECHK_B && bus_done && toggled) |=> ##[1:20] (!we_n && dq_out ==
        flash_host_pkg::CODE_RESET))
        else $error("reset command not issued after failure");
endmodule

// ---- tb/flash_model.sv ----
// Behavioural parallel NOR flash answering the host's bus cycles.
// Assumes word mode and the unlock and command codes of the shared package.
`timescale 1ns/100ps
module flash_model #(
    parameter int WINDOW_NS = 2000, // Arbitrary short acceptance time-out
    parameter int PROG_READS = 3,
    parameter int ERASE_READS = 8,
    parameter int FAIL_READS = 2
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [flash_host_pkg::ADDR_W-1:0] addr,
    input wire logic [flash_host_pkg::DATA_W-1:0] host_dq,
    input wire logic host_oe,
    output logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output logic ready_busy_out
);
    typedef enum logic [2:0] {ARRAY, PROG, WIN, ERS, SUSP, FAIL} mode_e;
    mode_e mode = ARRAY;
    logic [15:0] mem [int];
    logic [31:0] sectors = '0;
    logic [15:0] rd_val = '0;
    logic [15:0] pdata = '0;
    logic [19:0] paddr = '0;
    logic tog = 0;
    logic tog2 = 0;
    logic setup = 0;
    logic prog_next = 0;
    int u = 0;
    int left = 0;
    int saved = 0; // Erase count parked while a suspend-time program runs
    realtime win_end = 0;

    function automatic logic [15:0] rd_mem(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction

    // Each accepted sector restarts the whole time-out
    task automatic add_sector;
        sectors[addr[19:15]] = 1;
        win_end = $realtime + WINDOW_NS;
        mode = WIN;
        left = ERASE_READS;
    endtask

    // Command decoder, one step per completed write pulse
    always @(posedge we_n) begin
        if (!ce_n) begin
            if (mode == WIN && $realtime >= win_end) mode = ERS;
            if (prog_next) begin
                prog_next = 0;
                paddr = addr;
                pdata = host_dq;
                saved = (mode == SUSP) ? left : 0;
                left = ((~rd_mem(addr) & host_dq) != 0) ? FAIL_READS : PROG_READS;
                mode = ((~rd_mem(addr) & host_dq) != 0) ? FAIL : PROG;
            end else if (host_dq == flash_host_pkg::CODE_RESET) begin
                if (mode == FAIL) mode = ARRAY;
                u = 0;
            end else if (mode == ERS) begin
                if (host_dq == flash_host_pkg::CODE_SUSPEND) mode = SUSP;
            end else if (host_dq == flash_host_pkg::UNLOCK_CODE_A
                         && addr == flash_host_pkg::UNLOCK_ADDR_A) u = 1;
            else if (u == 1 && host_dq == flash_host_pkg::UNLOCK_CODE_B) u = 2;
            else if (u == 2) begin
                u = 0;
                prog_next = host_dq == flash_host_pkg::CODE_PROGRAM;
                if (setup && host_dq == flash_host_pkg::CODE_CHIP_ERASE) begin
                    sectors = '1; // No window for a whole-chip erase
                    left = ERASE_READS;
                    mode = ERS;
                end
                if (setup && host_dq == flash_host_pkg::CODE_SECTOR_ERASE) add_sector;
                setup = host_dq == flash_host_pkg::CODE_ERASE_SETUP;
            end else if (mode == SUSP && host_dq == flash_host_pkg::CODE_RESUME) mode = ERS;
            else if (mode == WIN && host_dq == flash_host_pkg::CODE_SECTOR_ERASE) add_sector;
            else u = 0;
        end
    end

    // Status or array word chosen at the start of each read
    always @(negedge oe_n) begin
        if (!ce_n) begin
            if (mode == WIN && $realtime >= win_end) mode = ERS;
            rd_val = rd_mem(addr);
            case (mode)
                PROG, FAIL: begin
                    tog = ~tog;
                    rd_val = {8'h00, ~pdata[7], tog, mode == FAIL && left <= 0, 5'h00};
                    left--;
                    if (mode == PROG && left == 0) begin
                        mem[paddr] = pdata;
                        mode = (saved > 0) ? SUSP : ARRAY; // Back to suspend if an erase was parked, else to array
                        left = saved;
                        saved = 0;
                    end
                end
                WIN, ERS: begin
                    tog = ~tog;
                    if (sectors[addr[19:15]]) tog2 = ~tog2;
                    rd_val = {9'h000, tog, 2'b00, mode == ERS, tog2, 2'b00};
                    if (mode == ERS) left--;
                    if (mode == ERS && left == 0) begin
                        foreach (mem[k]) if (sectors[k >> 15]) mem[k] = 16'hffff;
                        sectors = '0;
                        mode = ARRAY;
                    end
                end
                SUSP: if (sectors[addr[19:15]]) begin
                    tog2 = ~tog2;
                    rd_val = {8'h00, 1'b1, tog, 3'b000, tog2, 2'b00};
                end
                default: ;
            endcase
        end
    end

    // Released bus shows the inverse of the last word, never a held value
    assign dq_in = host_oe ? host_dq : (!ce_n && !oe_n) ? rd_val : ~rd_val;
    assign ready_busy_out = !(mode inside {PROG, WIN, ERS, FAIL});
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the flash write-status host controller.
// Assumes the behavioural flash model is wired straight to the pins.
`timescale 1ns/100ps
module tb_top;
    logic mclk = 0;
    logic resetn = 0;
    logic cmd_valid = 0;
    flash_host_pkg::op_e cmd_op = flash_host_pkg::OP_READ;
    logic [19:0] cmd_addr = '0;
    logic [15:0] cmd_data = '0;
    logic cmd_ready, done, result_fail, result_window, result_rejected, flash_ready;
    logic dq_oe, ce_n, oe_n, we_n, ready_busy_out;
    logic [15:0] result_data, dq_in, dq_out;
    logic [19:0] flash_addr;
    int errors = 0;
    int n_compared = 0;

    flash_status_host uut (.mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .done(done), .result_data(result_data), .result_fail(result_fail),
        .result_window(result_window), .result_rejected(result_rejected),
        .flash_ready(flash_ready), .flash_addr(flash_addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .ready_busy_out(ready_busy_out));
    flash_model flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(flash_addr),
        .host_dq(dq_out), .host_oe(dq_oe), .dq_in(dq_in), .ready_busy_out(ready_busy_out));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One command, held a single cycle since cmd_ready is high when idle
    task automatic run(input flash_host_pkg::op_e op, input logic [19:0] a,
                       input logic [15:0] d = 16'h0000);
        int n;
        n = 0;
        @(posedge mclk) #1;
        cmd_valid = 1;
        cmd_op = op;
        cmd_addr = a;
        cmd_data = d;
        @(posedge mclk) #1;
        cmd_valid = 0;
        while (done !== 1'b1 && n < 20000) begin
            @(posedge mclk) #2;
            n++;
        end
        check({15'h0000, done}, 16'h0001); // Bounded wait, counts a hang
    endtask

    // Program erased words, then read one back
    task automatic t_program;
        run(flash_host_pkg::OP_PROGRAM, 20'h1_0000, 16'h1234);
        check(result_fail, 16'h0000);
        run(flash_host_pkg::OP_PROGRAM, 20'h2_8000, 16'h5a5a);
        run(flash_host_pkg::OP_READ, 20'h1_0000);
        check(result_data, 16'h1234);
        check(flash_ready, 16'h0001);
    endtask

    // Turning a stored 0 into a 1 must fail, then reads give the array again
    task automatic t_fail;
        run(flash_host_pkg::OP_PROGRAM, 20'h1_0000, 16'hffff);
        check(result_fail, 16'h0001);
        run(flash_host_pkg::OP_READ, 20'h1_0000);
        check(result_data, 16'h1234);
        check(flash_ready, 16'h0001);
    endtask

    // Window restarts on each add, then closes and refuses; suspend and resume
    task automatic t_erase;
        logic [15:0] d1;
        run(flash_host_pkg::OP_SECTOR_ERASE, 20'h1_0000);
        check(result_window, 16'h0000);
        check(flash_ready, 16'h0000);
        // Each 100-cycle gap stays under the time-out, the sum does not: only a restart keeps it open
        repeat (100) @(posedge mclk);
        run(flash_host_pkg::OP_ADD_SECTOR, 20'h0_8000);
        check({result_rejected, result_window}, 16'h0000);
        repeat (100) @(posedge mclk);
        run(flash_host_pkg::OP_ADD_SECTOR, 20'h1_8000);
        check({result_rejected, result_window}, 16'h0000);
        repeat (300) @(posedge mclk);
        run(flash_host_pkg::OP_ADD_SECTOR, 20'h2_8000);
        check({result_rejected, result_window}, 16'h0003);
        run(flash_host_pkg::OP_READ, 20'h0_8000);
        d1 = result_data;
        run(flash_host_pkg::OP_READ, 20'h0_8000);
        check((d1 ^ result_data) & 16'h0044, 16'h0044);
        check(result_data & 16'h00a8, 16'h0008);
        run(flash_host_pkg::OP_SUSPEND, 20'h1_0000);
        check(flash_ready, 16'h0001);
        run(flash_host_pkg::OP_READ, 20'h1_0000);
        check(result_data & 16'h00a0, 16'h0080);
        run(flash_host_pkg::OP_READ, 20'h2_8000);
        check(result_data, 16'h5a5a);
        run(flash_host_pkg::OP_PROGRAM, 20'h3_0000, 16'h00c3);
        check({result_fail, flash_ready}, 16'h0001);
        run(flash_host_pkg::OP_RESUME, 20'h1_0000);
        run(flash_host_pkg::OP_WAIT, 20'h1_0000);
        check(result_fail, 16'h0000);
        run(flash_host_pkg::OP_READ, 20'h1_0000);
        check(result_data, 16'hffff);
        run(flash_host_pkg::OP_READ, 20'h2_8000);
        check(result_data, 16'h5a5a);
    endtask

    // Reset command while idle, then a whole-chip erase
    task automatic t_chip;
        run(flash_host_pkg::OP_RESET, 20'h0_0000);
        check(flash_ready, 16'h0001);
        // Chip erase is polled to its end inside the command, so ready is back
        run(flash_host_pkg::OP_CHIP_ERASE, 20'h0_0000);
        check({result_fail, flash_ready}, 16'h0001);
        run(flash_host_pkg::OP_WAIT, 20'h0_0000);
        run(flash_host_pkg::OP_READ, 20'h2_8000);
        check(result_data, 16'hffff);
    endtask

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Free-running clock
    always #5 mclk = ~mclk;

    // Reset, then the scenarios; extra cycles let the ready pin pass its synchroniser
    initial begin
        repeat (10) @(posedge mclk);
        #1 resetn = 1;
        repeat (6) @(posedge mclk);
        t_program;
        t_fail;
        t_erase;
        t_chip;
        end_of_test;
    end

    // Watchdog far beyond the expected few thousand cycles
    initial begin
        #1_000_000;
        errors++;
        end_of_test;
    end
endmodule
